/* File: pmc_pkg.sv */
/*
 * Constants for the MAC-side management register block: register
 * indices, field positions, reset values and speed codes.
 * Assumes a classic Wishbone slave with 32-bit data and byte addresses.
 */
`default_nettype none

package pmc_pkg;
    localparam int unsigned REG_W = 16;
    localparam int unsigned DAT_W = 32;
    localparam int unsigned IDX_W = 5;

    // Register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_FIFO_STATUS = 5'h13;
    localparam logic [IDX_W-1:0] IDX_CONTROL_TWO = 5'h15;
    localparam logic [IDX_W-1:0] IDX_IMPEDANCE = 5'h18;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 5'h1a;
    localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 5'h1b;
    localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 5'h1c;
    localparam logic [IDX_W-1:0] IDX_SOFT_RESET = 5'h1d;

    // Status field positions
    localparam int unsigned BIT_IDLE_INS = 3;
    localparam int unsigned BIT_IDLE_DEL = 2;
    localparam int unsigned FLAG_N = 2;

    // Control two field positions
    localparam int unsigned BIT_LINE_LOOP = 14;
    localparam int unsigned BIT_SPD_LSB = 13;
    localparam int unsigned BIT_SPD_MSB = 6;
    localparam int unsigned BIT_RX_TIMING = 5;
    localparam int unsigned BIT_TX_TIMING = 4;
    localparam int unsigned BIT_BLOCK_CEXT = 3;
    localparam logic [REG_W-1:0] CTL2_HW_RST = 16'h1076;
    localparam logic [REG_W-1:0] CTL2_WMASK = 16'he07f;
    localparam logic [REG_W-1:0] CTL2_FIXED = 16'h1000;
    localparam logic [REG_W-1:0] CTL2_SW_KEEP = 16'h3ff8;
    localparam logic [REG_W-1:0] CTL2_SW_SET = 16'h0006;

    // Impedance override field positions
    localparam int unsigned BIT_IMP_SC = 15;
    localparam int unsigned BIT_SUPPLY = 13;
    localparam int unsigned BIT_SENSE_1V8 = 12;
    localparam logic [REG_W-1:0] IMP_WMASK = 16'hafcf;
    localparam logic [3:0] CAL_HI_RST = 4'h8;
    localparam logic [3:0] CAL_LO_RST = 4'h8;

    // Soft reset control bit
    localparam int unsigned BIT_SOFT_RESET = 0;

    // Strap settle cycles after reset release
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    typedef enum logic [1:0] {
        PMC_SPD_10 = 2'h0,
        PMC_SPD_100 = 2'h1,
        PMC_SPD_1000 = 2'h2
    } pmc_speed_t;
endpackage

`default_nettype wire

/* File: pmc_sync2.sv */
/*
 * Two-stage synchroniser for pins from outside the clock domain.
 * Assumes one clock, a synchronous active-low reset and a clock enable.
 */
`default_nettype none

module pmc_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            meta <= '0;
            q <= '0;
        end else if (ce) begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // pmc_sync2

`default_nettype wire

/* File: pmc_flag_bank.sv */
/*
 * Bank of sticky flags; a set in the same cycle as a clear wins.
 * Assumes set and clear come from logic on the same clock.
 */
`default_nettype none

module pmc_flag_bank #(
    parameter int unsigned WIDTH = 2
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clr,
    output logic [WIDTH-1:0] q
);
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            q <= '0;
        end else if (ce) begin
            q <= (q & ~clr) | set;
        end
    end
endmodule // pmc_flag_bank

`default_nettype wire

/* File: pmc_mac_side_regs.sv */
/*
 * MAC-side management registers: latched FIFO idle status, line loopback,
 * default MAC speed, receive and transmit clock timing, carrier extension
 * blocking and I/O supply level, reached over classic Wishbone.
 * Assumes FIFO events, link state and speed come from same-clock logic;
 * strap and supply sense pins are asynchronous.
 */
// The Wishbone slave port was chosen for this implementation.
`default_nettype none

module pmc_mac_side_regs #(
    parameter int unsigned ADDR_W = 8,
    parameter logic [3:0] CAL_HI = pmc_pkg::CAL_HI_RST,
    parameter logic [3:0] CAL_LO = pmc_pkg::CAL_LO_RST
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [pmc_pkg::DAT_W-1:0] wb_dat_i,
    output logic [pmc_pkg::DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic idle_inserted,
    input wire logic idle_deleted,
    input wire logic link_up,
    input wire logic mac_loopback,
    input wire pmc_pkg::pmc_speed_t link_speed,
    input wire logic [1:0] strap_cfg,
    input wire logic io_1v8_sense,
    output pmc_pkg::pmc_speed_t mac_if_speed,
    output logic line_loopback,
    output logic rx_clk_mid_data,
    output logic tx_clk_delay,
    output logic block_carrier_ext,
    output logic io_supply_level,
    output logic soft_reset,
    output logic irq
);
    import pmc_pkg::*;

    logic wb_req;
    logic wr_take;
    logic rd_take;
    logic [IDX_W-1:0] idx;
    logic [REG_W-1:0] wdata;
    logic [REG_W-1:0] rdata;
    logic [REG_W-1:0] ctl2;
    logic [REG_W-1:0] imp;
    logic [FLAG_N-1:0] events;
    logic [FLAG_N-1:0] fifo_flags;
    logic [FLAG_N-1:0] fifo_clr;
    logic [FLAG_N-1:0] irq_flags;
    logic [FLAG_N-1:0] irq_clr;
    logic [FLAG_N-1:0] irq_en;
    logic [1:0] strap_sync;
    logic sense_sync;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic [1:0] act_spd;
    logic act_rx;
    logic act_tx;

    // Byte-lane merge of a 16-bit register
    function automatic logic [REG_W-1:0] merge(
        input logic [REG_W-1:0] old,
        input logic [REG_W-1:0] data,
        input logic [1:0] sel
    );
        logic [REG_W-1:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = data[7:0];
        end
        if (sel[1]) begin
            r[15:8] = data[15:8];
        end
        return r;
    endfunction

    // Default speed decode from bits 6 and 13
    function automatic pmc_speed_t speed_of(input logic [1:0] msb_lsb);
        pmc_speed_t s;
        s = PMC_SPD_1000;
        if (msb_lsb == 2'h0) begin
            s = PMC_SPD_10;
        end
        return s;
    endfunction

    assign wb_req = wb_cyc_i & wb_stb_i;
    assign idx = wb_adr_i[IDX_W+1:2];
    assign wdata = wb_dat_i[REG_W-1:0];
    assign wr_take = wb_req & wb_we_i & wb_ack_o;
    assign rd_take = wb_req & ~wb_we_i & wb_ack_o;
    assign events = {idle_inserted, idle_deleted};

    pmc_sync2 #(
        .WIDTH(2)
    ) u_strap_sync (
        .clock(clock),
        .rst_b(rst_b),
        .ce(ce),
        .d(strap_cfg),
        .q(strap_sync)
    );

    pmc_sync2 #(
        .WIDTH(1)
    ) u_sense_sync (
        .clock(clock),
        .rst_b(rst_b),
        .ce(ce),
        .d(io_1v8_sense),
        .q(sense_sync)
    );

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
        end else if (ce) begin
            wb_ack_o <= wb_req & ~wb_ack_o;
        end
    end

    // Read mux
    always_comb begin
        rdata = '0;
        case (idx)
            IDX_FIFO_STATUS: begin
                rdata[BIT_IDLE_INS] = fifo_flags[1];
                rdata[BIT_IDLE_DEL] = fifo_flags[0];
            end
            IDX_CONTROL_TWO: begin
                rdata = (ctl2 & CTL2_WMASK) | CTL2_FIXED;
            end
            IDX_IMPEDANCE: begin
                rdata = imp & IMP_WMASK;
                rdata[BIT_SENSE_1V8] = sense_sync;
            end
            IDX_IRQ_STATUS: begin
                rdata[FLAG_N-1:0] = irq_flags;
            end
            IDX_IRQ_ENABLE: begin
                rdata[FLAG_N-1:0] = irq_en;
            end
            default: begin
                rdata = '0;
            end
        endcase
    end

    // Read data held through the ack cycle
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wb_dat_o <= '0;
        end else if (ce) begin
            if (wb_req & ~wb_we_i & ~wb_ack_o) begin
                wb_dat_o <= {{(DAT_W-REG_W){1'b0}}, rdata};
            end
        end
    end

    always_comb begin
        fifo_clr = '0;
        if (rd_take && idx == IDX_FIFO_STATUS) begin
            fifo_clr = {wb_dat_o[BIT_IDLE_INS], wb_dat_o[BIT_IDLE_DEL]};
        end
        if (soft_reset) begin
            fifo_clr = '1;
        end
    end

    pmc_flag_bank #(
        .WIDTH(FLAG_N)
    ) u_fifo_flags (
        .clock(clock),
        .rst_b(rst_b),
        .ce(ce),
        .set(events),
        .clr(fifo_clr),
        .q(fifo_flags)
    );

    // Write-one-to-clear of interrupt status
    always_comb begin
        irq_clr = '0;
        if (wr_take && idx == IDX_IRQ_CLEAR && wb_sel_i[0]) begin
            irq_clr = wdata[FLAG_N-1:0];
        end
    end

    pmc_flag_bank #(
        .WIDTH(FLAG_N)
    ) u_irq_flags (
        .clock(clock),
        .rst_b(rst_b),
        .ce(ce),
        .set(events),
        .clr(irq_clr),
        .q(irq_flags)
    );

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            irq_en <= '0;
        end else if (ce) begin
            if (wr_take && idx == IDX_IRQ_ENABLE && wb_sel_i[0]) begin
                irq_en <= wdata[FLAG_N-1:0];
            end
        end
    end

    assign irq = |(irq_flags & irq_en);

    // Soft reset pulse, self-clearing
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            soft_reset <= 1'b0;
        end else if (ce) begin
            soft_reset <= wr_take && idx == IDX_SOFT_RESET &&
                wb_sel_i[0] && wdata[BIT_SOFT_RESET];
        end
    end

    // Control two: reset behaviour and stored fields
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ctl2 <= CTL2_HW_RST;
        end else if (ce) begin
            if (soft_reset) begin
                ctl2 <= (ctl2 & CTL2_SW_KEEP) | CTL2_SW_SET;
            end else if (wr_take && idx == IDX_CONTROL_TWO) begin
                ctl2 <= (merge(ctl2, wdata, wb_sel_i[1:0]) & CTL2_WMASK) |
                    CTL2_FIXED;
            end
        end
    end

    // speed and timing bits act after soft reset
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            act_spd <= {CTL2_HW_RST[BIT_SPD_MSB], CTL2_HW_RST[BIT_SPD_LSB]};
            act_rx <= CTL2_HW_RST[BIT_RX_TIMING];
            act_tx <= CTL2_HW_RST[BIT_TX_TIMING];
        end else if (ce) begin
            if (soft_reset) begin
                act_spd <= {ctl2[BIT_SPD_MSB], ctl2[BIT_SPD_LSB]};
                act_rx <= ctl2[BIT_RX_TIMING];
                act_tx <= ctl2[BIT_TX_TIMING];
            end
        end
    end

    // default speed while link down or MAC loopback
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            mac_if_speed <= PMC_SPD_1000;
        end else if (ce) begin
            if (!link_up || mac_loopback) begin
                mac_if_speed <= speed_of(act_spd);
            end else begin
                mac_if_speed <= link_speed;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            line_loopback <= CTL2_HW_RST[BIT_LINE_LOOP];
            block_carrier_ext <= CTL2_HW_RST[BIT_BLOCK_CEXT];
        end else if (ce) begin
            line_loopback <= ctl2[BIT_LINE_LOOP];
            block_carrier_ext <= ctl2[BIT_BLOCK_CEXT];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rx_clk_mid_data <= CTL2_HW_RST[BIT_RX_TIMING];
            tx_clk_delay <= CTL2_HW_RST[BIT_TX_TIMING];
        end else if (ce) begin
            rx_clk_mid_data <= act_rx;
            tx_clk_delay <= act_tx;
        end
    end

    // Supply level output follows the stored supply bit
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            io_supply_level <= 1'b0;
        end else if (ce) begin
            io_supply_level <= imp[BIT_SUPPLY];
        end
    end

    // Strap settle counter after reset release
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            strap_cnt <= '0;
            strap_done <= 1'b0;
        end else if (ce) begin
            if (!strap_done) begin
                if (strap_cnt == STRAP_SETTLE) begin
                    strap_done <= 1'b1;
                end else begin
                    strap_cnt <= strap_cnt + 2'h1;
                end
            end
        end
    end

    // Impedance override register
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            imp <= {4'h0, CAL_HI, 4'h0, CAL_LO};
        end else if (ce) begin
            if (wr_take && idx == IDX_IMPEDANCE) begin
                imp <= merge(imp, wdata, wb_sel_i[1:0]) & IMP_WMASK;
            end else begin
                // Reserved strobe bit clears itself
                imp[BIT_IMP_SC] <= 1'b0;
            end
            if (!strap_done && strap_cnt == STRAP_SETTLE) begin
                imp[BIT_SUPPLY] <= ^strap_sync;
            end
        end
    end
endmodule // pmc_mac_side_regs

`default_nettype wire

/* File: pmc_mac_side_regs_chk.sv */
/* Checker for the MAC-side register block, bound below.
   Assumes ce is held high. */
`default_nettype none
module pmc_mac_side_regs_chk #(
    parameter int unsigned ADDR_W = 8,
    parameter logic [3:0] CAL_HI = pmc_pkg::CAL_HI_RST,
    parameter logic [3:0] CAL_LO = pmc_pkg::CAL_LO_RST
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic idle_inserted,
    input wire logic idle_deleted,
    input wire logic link_up,
    input wire logic mac_loopback,
    input wire logic [1:0] strap_cfg,
    input wire logic io_1v8_sense,
    input wire pmc_pkg::pmc_speed_t mac_if_speed,
    input wire logic line_loopback,
    input wire logic rx_clk_mid_data,
    input wire logic tx_clk_delay,
    input wire logic block_carrier_ext,
    input wire logic io_supply_level,
    input wire logic soft_reset
);
    timeunit 1ns;
    timeprecision 1ns;
    import pmc_pkg::*;
    logic wr2, rd_st, rd_im, r5, r4, s6, s13, a6, a13;
    pmc_speed_t spd;
    assign wr2 = wb_ack_o && wb_we_i && wb_adr_i[6:2] == IDX_CONTROL_TWO;
    assign rd_st = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
        && wb_adr_i[6:2] == IDX_FIFO_STATUS;
    assign rd_im = wb_ack_o && !wb_we_i && wb_adr_i[6:2] == IDX_IMPEDANCE;
    assign spd = (a6 | a13) ? PMC_SPD_1000 : PMC_SPD_10;
    // Written and active speed and timing bits
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            {r5, r4, s6, s13, a6, a13} <= 6'b111010;
        end else begin
            if (wr2 && wb_sel_i[0]) begin
                {s6, r5, r4} <= wb_dat_i[6:4];
            end
            if (wr2 && wb_sel_i[1]) begin
                s13 <= wb_dat_i[13];
            end
            if (soft_reset) begin
                {a6, a13} <= {s6, s13};
            end
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    property p_ins;
        idle_inserted ##1 rd_st |=> wb_dat_o[BIT_IDLE_INS];
    endproperty
    a_ins: assert property (p_ins)
        else $error("idle insert flag missing");
    property p_del;
        idle_deleted ##1 rd_st |=> wb_dat_o[BIT_IDLE_DEL];
    endproperty
    a_del: assert property (p_del)
        else $error("idle delete flag missing");
    property p_loop;
        wr2 && wb_sel_i[1] |-> ##2 line_loopback == $past(wb_dat_i[14], 2);
    endproperty
    a_loop: assert property (p_loop)
        else $error("line loopback not following write");
    property p_cext;
        wr2 && wb_sel_i[0] |-> ##2 block_carrier_ext == $past(wb_dat_i[3], 2);
    endproperty
    a_cext: assert property (p_cext)
        else $error("carrier block not following write");
    property p_hold;
        $changed(rx_clk_mid_data) || $changed(tx_clk_delay)
            |-> $past(soft_reset) || $past(soft_reset, 2);
    endproperty
    a_hold: assert property (p_hold)
        else $error("timing changed without soft reset");
    property p_rxtx;
        soft_reset |-> ##2 rx_clk_mid_data == $past(r5, 2)
            && tx_clk_delay == $past(r4, 2);
    endproperty
    a_rxtx: assert property (p_rxtx)
        else $error("timing bits not loaded");
    property p_down;
        (!link_up && !soft_reset) [*3] |-> mac_if_speed == spd;
    endproperty
    a_down: assert property (p_down)
        else $error("link down speed wrong");
    property p_loopb;
        (link_up && mac_loopback && !soft_reset) [*3] |-> mac_if_speed == spd;
    endproperty
    a_loopb: assert property (p_loopb)
        else $error("loopback speed wrong");
    property p_strap;
        $rose(rst_b) |-> !io_supply_level [*3]
            ##[2:4] io_supply_level == ^strap_cfg;
    endproperty
    a_strap: assert property (p_strap)
        else $error("supply level not from straps");
    property p_sense;
        rd_im |-> wb_dat_o[BIT_SENSE_1V8] == io_1v8_sense
            && wb_dat_o[11:8] == CAL_HI && wb_dat_o[3:0] == CAL_LO;
    endproperty
    a_sense: assert property (p_sense)
        else $error("impedance read wrong");
    c_sr: cover property (soft_reset);
    c_ins: cover property (rd_st ##1 wb_dat_o[BIT_IDLE_INS]);
    c_lb: cover property (link_up && mac_loopback);
endmodule // pmc_mac_side_regs_chk

bind pmc_mac_side_regs pmc_mac_side_regs_chk #(
    .ADDR_W(ADDR_W), .CAL_HI(CAL_HI), .CAL_LO(CAL_LO)
) u_chk (
    .clock(clock), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .idle_inserted(idle_inserted),
    .idle_deleted(idle_deleted), .link_up(link_up),
    .mac_loopback(mac_loopback), .strap_cfg(strap_cfg),
    .io_1v8_sense(io_1v8_sense), .mac_if_speed(mac_if_speed),
    .line_loopback(line_loopback), .rx_clk_mid_data(rx_clk_mid_data),
    .tx_clk_delay(tx_clk_delay), .block_carrier_ext(block_carrier_ext),
    .io_supply_level(io_supply_level), .soft_reset(soft_reset)
);
`default_nettype wire

/* File: pmc_mac_model.sv */
/* Far-side stand-in making copper FIFO idle insert and delete events.
   Assumes its inputs change on the rising clock edge. */
`default_nettype none
module pmc_mac_model (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ev_on,
    input wire logic [1:0] ev_force,
    output logic idle_inserted,
    output logic idle_deleted
);
    timeunit 1ns;
    timeprecision 1ns;
    integer seed = 32'hde1ca1af;
    logic [31:0] r;
    // Forced or random one-cycle events
    always @(posedge clock) begin
        r = $random(seed);
        idle_inserted <= rst_b && (ev_force[1] || (ev_on && r[1:0] == 2'h3));
        idle_deleted <= rst_b && (ev_force[0] || (ev_on && r[3:2] == 2'h3));
    end
endmodule // pmc_mac_model
`default_nettype wire

/* File: pmc_mac_side_regs_tb.sv */
/* Self-checking bench for the MAC-side register block.
   Assumes the checker is bound and the far-side model makes events. */
`default_nettype none
module pmc_mac_side_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pmc_pkg::*;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic lnk = 1'b0;
    logic lpb = 1'b0;
    logic ev_on = 1'b0;
    logic [1:0] frc = 2'h0;
    logic [3:0] sel = 4'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack, ins, del, llb, rxt, txd, cex, lvl, srst, irq;
    pmc_speed_t lspd = PMC_SPD_10;
    pmc_speed_t spd;
    int failures = 0;
    int n_tests = 0;
    integer seed = 32'hde1ca1af;
    logic [15:0] q, d, c2, a, m;
    logic [3:0] bs;
    logic [1:0] stp = 2'b10;
    logic sns = 1'b1;
    always #25 clock = ~clock;
    pmc_mac_side_regs dut (.clock(clock), .rst_b(rst_b), .ce(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .idle_inserted(ins), .idle_deleted(del), .link_up(lnk),
        .mac_loopback(lpb), .link_speed(lspd), .strap_cfg(stp),
        .io_1v8_sense(sns), .mac_if_speed(spd), .line_loopback(llb),
        .rx_clk_mid_data(rxt), .tx_clk_delay(txd),
        .block_carrier_ext(cex), .io_supply_level(lvl),
        .soft_reset(srst), .irq(irq));
    pmc_mac_model mac (.clock(clock), .rst_b(rst_b), .ev_on(ev_on),
        .ev_force(frc), .idle_inserted(ins), .idle_deleted(del));
    task automatic chk(input string s, input logic [15:0] g, e);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] ad,
        input logic [15:0] v, input logic [3:0] s);
        int n;
        @(posedge clock);
        cyc <= 1'b1;
        we <= w;
        adr <= ad;
        wdat <= {16'h0, v};
        sel <= s;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1);
        q = rdat[15:0];
        cyc <= 1'b0;
        // Ack comes the cycle after the request is seen
        chk("ack_wait", 16'(n), 16'h2);
    endtask
    task automatic rd(input logic [7:0] ad);
        bus(1'b0, ad, 16'h0, 4'hf);
    endtask
    function automatic pmc_speed_t dspd(input logic [15:0] c);
        return (c[6] | c[13]) ? PMC_SPD_1000 : PMC_SPD_10;
    endfunction
    task automatic pchk;
        chk("ports", {12'h0, llb, cex, rxt, txd},
            {12'h0, c2[14], c2[3], a[5:4]});
        chk("speed", {14'h0, spd}, {14'h0, dspd(a)});
    endtask
    task automatic pulse(input logic [1:0] k);
        @(posedge clock);
        frc <= k;
        @(posedge clock);
        frc <= 2'h0;
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        wrap_up;
    end
    initial begin
        c2 = 16'h1076;
        a = c2;
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        repeat (8) @(posedge clock);
        pchk();
        chk("lvl", {15'h0, lvl}, 16'h1);
        rd(8'h54);
        chk("ctl2", q, 16'h1076);
        rd(8'h60);
        chk("imp", q, {4'h3, CAL_HI_RST, 4'h0, CAL_LO_RST});
        bus(1'b1, 8'h60, q & 16'hdfff, 4'h3);
        rd(8'h60);
        chk("imp_w", q, {4'h1, CAL_HI_RST, 4'h0, CAL_LO_RST});
        chk("lvl_w", {15'h0, lvl}, 16'h0);
        bus(1'b1, 8'h08, 16'hffff, 4'hf);
        rd(8'h08);
        chk("unmapped", q, 16'h0);
        for (int k = 1; k < 4; k++) begin
            pulse(k[1:0]);
            rd(8'h4c);
            chk("flags", q, {12'h0, k[1:0], 2'b00});
            rd(8'h4c);
            chk("cleared", q, 16'h0);
        end
        bus(1'b1, 8'h70, 16'h0003, 4'hf);
        bus(1'b1, 8'h6c, 16'h0002, 4'hf);
        pulse(2'h3);
        repeat (3) @(posedge clock);
        chk("irq", {15'h0, irq}, 16'h1);
        rd(8'h68);
        chk("irq_stat", q, 16'h0003);
        bus(1'b1, 8'h70, 16'h0002, 4'hf);
        repeat (2) @(posedge clock);
        chk("irq_mask", {15'h0, irq}, 16'h0);
        ev_on <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            d = (i == 0) ? 16'h0 : (i == 1) ? 16'hffff : 16'($random(seed));
            bs = (i < 2) ? 4'h3 : 4'(1 + i % 3);
            m = {{8{bs[1]}}, {8{bs[0]}}};
            c2 = (c2 & ~m) | (d & m);
            bus(1'b1, 8'h54, d, bs);
            rd(8'h54);
            chk("ctl2_w", q, {c2[15:13], 6'h20, c2[6:0]});
            pchk();
            bus(1'b1, 8'h74, 16'h0001, 4'hf);
            c2 = {2'b00, c2[13:3], 3'h6};
            a = c2;
            rd(8'h54);
            chk("ctl2_s", q, {c2[15:13], 6'h20, c2[6:0]});
            pchk();
            lnk <= 1'b1;
            lpb <= 1'b1;
            lspd <= dspd(a);
            repeat (4) @(posedge clock);
            chk("speed_lb", {14'h0, spd}, {14'h0, dspd(a)});
            lpb <= 1'b0;
            lspd <= PMC_SPD_100;
            repeat (3) @(posedge clock);
            chk("speed_up", {14'h0, spd}, {14'h0, PMC_SPD_100});
            lnk <= 1'b0;
        end
        // Second hardware reset with other straps and sense level
        stp <= 2'b01;
        sns <= 1'b0;
        rst_b <= 1'b0;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        c2 = 16'h1076;
        a = c2;
        repeat (8) @(posedge clock);
        pchk();
        chk("lvl_rst", {15'h0, lvl}, 16'h1);
        rd(8'h60);
        chk("imp_rst", q, {4'h2, CAL_HI_RST, 4'h0, CAL_LO_RST});
        wrap_up;
    end
endmodule // pmc_mac_side_regs_tb
`default_nettype wire
